// *** common/chc_pkg.sv ***
/*
  Shared constants and carrier types for the card host control signal block.
  Assumes a single 125 MHz clock and pins already reduced to in/out/oe triples.
*/
package chc_pkg;

  // Operating modes; memory and IDE are latched at reset release, I/O is set later.
  typedef enum logic [1:0] {
    MODE_MEM = 2'b00,
    MODE_IO  = 2'b01,
    MODE_IDE = 2'b10
  } chc_mode_type;

  // Card initialization state.
  typedef enum logic [1:0] {
    ST_INIT  = 2'b00,
    ST_RUN   = 2'b01,
    ST_RSTHD = 2'b10
  } chc_state_type;

  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned INIT_TIME_US = 100;
  localparam int unsigned INIT_CYCLES = INIT_TIME_US * CLK_MHZ;
  localparam int unsigned CNT_W = 24;
  // Pin synchronisers start at the idle level of every host strobe and select, so that no
  // false strobe edge follows reset.
  localparam logic [4:0] SYNC_RST = 5'h1F;
  localparam logic [1:0] PULSE_RST = 2'h0;
  localparam int unsigned PULSE_CYCLES = 4;

  // Host strobe and select inputs as sampled by the card.
  typedef struct packed {
    logic reset_pin;
    logic reg_sel_n;
    logic we_n;
    logic dmack_n;
    logic mode_sel_n;
  } chc_host_in_type;

  // Events raised by the card core.
  typedef struct packed {
    logic busy;
    logic irq;
    logic irq_level_mode;
    logic dma_enabled;
    logic port16;
    logic word_xfer;
    // High once the host has configured the I/O interface.
    logic io_sel;
  } chc_core_in_type;

endpackage : chc_pkg

// *** dv/chc_host_model.sv ***
/* Host socket model driving the card's control pins.
   Assumes the bench calls its tasks just after a rising clock edge. */
module chc_host_model (
  // Clock and card status
  input wire logic ref_clk_i,
  input wire logic rdy_i,
  // Host pins
  output chc_pkg::chc_host_in_type host_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial host_o = '{reset_pin: 1'b1, reg_sel_n: 1'b1, we_n: 1'b1, dmack_n: 1'b1,
    mode_sel_n: 1'b1};
  task put(input chc_pkg::chc_host_in_type v);
    @(posedge ref_clk_i) #1 host_o = v;
  endtask : put
  task strobe_we();
    while (rdy_i !== 1'b1) @(posedge ref_clk_i);
    @(posedge ref_clk_i) #1 host_o.we_n = 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1 host_o.we_n = 1'b1;
  endtask : strobe_we
endmodule : chc_host_model

// *** dv/chc_props.sv ***
/* Port checker for chc_top.
   Assumes it is bound to chc_top and sees only its ports. */
module chc_props (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Watched ports
  input wire chc_pkg::chc_core_in_type core_i,
  input wire logic common_sel_o,
  input wire logic attr_sel_o,
  input wire logic mem_write_o,
  input wire logic cfg_write_o,
  input wire logic dma_ack_o,
  input wire logic card_reset_o,
  input wire logic init_done_o,
  input wire logic [1:0] mode_o,
  input wire logic rdy_irq_o,
  input wire logic wp_io16_o,
  input wire logic wait_n_o,
  input wire logic wait_oe_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  logic mem_run;
  logic mem_init;
  assign mem_run = init_done_o && (mode_o == chc_pkg::MODE_MEM);
  assign mem_init = !init_done_o && !card_reset_o && (mode_o == chc_pkg::MODE_MEM);
  a_wait_never: assert property (wait_n_o && wait_oe_o)
    else $error("wait pin driven");
  a_ready_busy: assert property ((mem_run && core_i.busy) [*4] |-> !rdy_irq_o)
    else $error("ready high while busy");
  a_ready_init: assert property (mem_init [*2] |-> !rdy_irq_o)
    else $error("ready high during init");
  a_ide_irq: assert property
    ((init_done_o && mode_o == chc_pkg::MODE_IDE && core_i.irq) [*4] |-> rdy_irq_o)
    else $error("interrupt not high");
  a_dma_ignore: assert property (!core_i.dma_enabled [*2] |-> !dma_ack_o)
    else $error("acknowledge passed while disabled");
  a_gate_init: assert property
    (!init_done_o [*2] |-> !(common_sel_o || attr_sel_o || mem_write_o || cfg_write_o))
    else $error("decode active before init");
  a_write_pulse: assert property (mem_write_o |=> !mem_write_o)
    else $error("write pulse too long");
  a_sel_excl: assert property (!(common_sel_o && attr_sel_o))
    else $error("both memory spaces selected");
  a_wp_run: assert property (mem_run [*3] |-> !wp_io16_o)
    else $error("write protect high after init");
  a_io_level: assert property
    ((init_done_o && mode_o == chc_pkg::MODE_IO && core_i.irq_level_mode && core_i.irq) [*2]
      |-> !rdy_irq_o)
    else $error("level interrupt not low");
  a_io_port16: assert property
    ((init_done_o && mode_o == chc_pkg::MODE_IO && core_i.port16) [*2] |-> !wp_io16_o)
    else $error("port width indication not low");
endmodule : chc_props

bind chc_top chc_props i_props (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .core_i(core_i),
  .common_sel_o(common_sel_o), .attr_sel_o(attr_sel_o), .mem_write_o(mem_write_o),
  .cfg_write_o(cfg_write_o), .dma_ack_o(dma_ack_o), .card_reset_o(card_reset_o),
  .init_done_o(init_done_o), .mode_o(mode_o), .rdy_irq_o(rdy_irq_o),
  .wp_io16_o(wp_io16_o), .wait_n_o(wait_n_o), .wait_oe_o(wait_oe_o));

// *** dv/tb_top.sv ***
/* Self-checking bench for chc_top in memory, I/O and IDE modes.
   Assumes the full 12500 cycle initialization count. */
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  chc_pkg::chc_core_in_type core = '0;
  chc_pkg::chc_host_in_type hv;
  logic csel, asel, mwr, cwr, dack, crst, idone, rdy, rdy_oe, wp, wt, wt_oe;
  logic [1:0] mode;
  logic [31:0] lf = 32'hC7ED;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  int m;
  chc_host_model i_host (.ref_clk_i(ref_clk_i), .rdy_i(rdy), .host_o(hv));
  chc_top i_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .host_i(hv), .core_i(core),
    .common_sel_o(csel), .attr_sel_o(asel), .mem_write_o(mwr), .cfg_write_o(cwr),
    .dma_ack_o(dack), .card_reset_o(crst), .init_done_o(idone), .mode_o(mode),
    .rdy_irq_o(rdy), .rdy_irq_oe_o(rdy_oe), .wp_io16_o(wp), .wait_n_o(wt),
    .wait_oe_o(wt_oe));
  initial forever #4 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      stop_test();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic exp_rdy(input logic ide, input logic busy, input logic irq);
    return ide ? irq : ~busy;
  endfunction : exp_rdy
  task chk_bit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task chk_mode(input string nm, input logic [1:0] e, input logic [1:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_mode
  task chk_count(input string nm, input int e, input int g);
    num_checks++;
    if (g != e) begin
      fail_count++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_count
  task wait_init();
    n = 0;
    while (idone !== 1'b1 && n < 13000) begin
      @(posedge ref_clk_i);
      n++;
    end
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask : wait_init
  task stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  initial begin
    repeat (16) @(posedge ref_clk_i);
    #1 rstn_i = 1'b1;
    repeat (20) @(posedge ref_clk_i);
    #1;
    chk_bit("card_reset", 1'b1, crst);
    chk_bit("ready_held", 1'b1, rdy);
    i_host.put('{1'b0, 1'b1, 1'b1, 1'b1, 1'b1});
    repeat (10) @(posedge ref_clk_i);
    chk_bit("ready_init", 1'b0, rdy);
    wait_init();
    chk_bit("init_done", 1'b1, idone);
    chk_bit("ready_oe", 1'b1, rdy_oe);
    chk_bit("ready_run", 1'b1, rdy);
    chk_bit("wp", 1'b0, wp);
    chk_mode("mode", chc_pkg::MODE_MEM, mode);
    $display("test memory init ended");
    repeat (40) begin
      lf = lfsr(lf);
      i_host.put('{1'b0, lf[1], 1'b1, lf[2], 1'b1});
      core.busy = lf[0];
      repeat (6) @(posedge ref_clk_i);
      #1;
      chk_bit("ready", exp_rdy(1'b0, lf[0], 1'b0), rdy);
      chk_bit("common", lf[1], csel);
      chk_bit("attr", ~lf[1], asel);
      chk_bit("dma_ack", 1'b0, dack);
    end
    core.busy = 1'b0;
    repeat (6) @(posedge ref_clk_i);
    i_host.strobe_we();
    n = 0;
    repeat (10) begin
      @(posedge ref_clk_i);
      #1 n += int'(mwr === 1'b1);
    end
    chk_count("write_pulse", 1, n);
    // Register select held low for I/O
    i_host.put('{1'b0, 1'b0, 1'b1, 1'b1, 1'b1});
    core.io_sel = 1'b1;
    core.irq_level_mode = 1'b1;
    repeat (6) @(posedge ref_clk_i);
    #1;
    chk_mode("mode_io", chc_pkg::MODE_IO, mode);
    chk_bit("io_common", 1'b0, csel);
    repeat (20) begin
      lf = lfsr(lf);
      core.irq = lf[0];
      core.port16 = lf[1];
      repeat (3) @(posedge ref_clk_i);
      #1;
      chk_bit("irq_level", ~lf[0], rdy);
      chk_bit("io_port16", ~lf[1], wp);
    end
    core.irq = 1'b0;
    core.irq_level_mode = 1'b0;
    repeat (6) @(posedge ref_clk_i);
    #1 core.irq = 1'b1;
    n = 0;
    repeat (12) begin
      @(posedge ref_clk_i);
      #1 n += int'(rdy === 1'b0);
    end
    chk_count("irq_pulse", int'(chc_pkg::PULSE_CYCLES), n);
    core.irq = 1'b0;
    i_host.strobe_we();
    n = 0;
    m = 0;
    repeat (10) begin
      @(posedge ref_clk_i);
      #1 n += int'(cwr === 1'b1);
      m += int'(mwr === 1'b1);
    end
    chk_count("cfg_write", 1, n);
    chk_count("io_mem_write", 0, m);
    core.io_sel = 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1;
    chk_mode("mode_mem", chc_pkg::MODE_MEM, mode);
    $display("test io ended");
    i_host.put('{1'b1, 1'b1, 1'b1, 1'b1, 1'b1});
    repeat (8) @(posedge ref_clk_i);
    chk_bit("mem_reset", 1'b1, crst);
    $display("test memory traffic ended");
    #1 rstn_i = 1'b0;
    i_host.put('{1'b1, 1'b1, 1'b1, 1'b1, 1'b0});
    #1 rstn_i = 1'b1;
    wait_init();
    chk_mode("mode", chc_pkg::MODE_IDE, mode);
    chk_bit("ide_reset_off", 1'b0, crst);
    repeat (30) begin
      lf = lfsr(lf);
      // Acknowledge as a DMA answer, selects idle
      i_host.put('{1'b1, 1'b1, 1'b1, lf[2], 1'b0});
      core = '{1'b0, lf[0], 1'b0, lf[1], 1'b0, lf[3], 1'b0};
      repeat (6) @(posedge ref_clk_i);
      #1;
      chk_bit("intrq", exp_rdy(1'b1, 1'b0, lf[0]), rdy);
      chk_bit("dma_ack", lf[1] & ~lf[2], dack);
      chk_bit("iocs16", ~lf[3], wp);
      chk_bit("wait", 1'b1, wt);
      chk_bit("wait_oe", 1'b1, wt_oe);
    end
    i_host.put('{1'b0, 1'b1, 1'b1, 1'b1, 1'b0});
    repeat (8) @(posedge ref_clk_i);
    chk_bit("ide_reset", 1'b1, crst);
    $display("test ide ended");
    stop_test();
  end
endmodule : tb_top

// *** hdl/chc_top.sv ***
/*
  Control and status signal logic of a flash card host port in memory, I/O and
  IDE modes. Assumes host pins arrive asynchronously and card core signals are
  synchronous to ref_clk_i. Pins are sampled through three flops.
*/
// Overview of operation
// - Memory mode: ready low busy, high idle
// - Ready low until initialization finishes
// - Memory mode: reset held or open before its first release keeps ready high
// - I/O mode: interrupt pulsed or held low
// - IDE mode: interrupt request active high
// - Register select: high common, low attribute
// - DMA disabled: ignore acknowledge completely
// - PC Card modes: reset active high
// - IDE mode: host reset active low
// - Wait/IORDY is never asserted
// - Memory mode: write strobe latches data
// - I/O mode: write strobe configuration only
// - Memory mode: write-protect low after init
// - I/O mode: 16-bit port indication low
// - IDE mode: word transfer indication low
module chc_top (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Host pins
  input wire chc_pkg::chc_host_in_type host_i,
  // Card core
  input wire chc_pkg::chc_core_in_type core_i,
  // Decoded strobes towards the card core
  output logic common_sel_o,
  output logic attr_sel_o,
  output logic mem_write_o,
  output logic cfg_write_o,
  output logic dma_ack_o,
  output logic card_reset_o,
  output logic init_done_o,
  output logic [1:0] mode_o,
  // Shared card pins
  output logic rdy_irq_o,
  output logic rdy_irq_oe_o,
  output logic wp_io16_o,
  output logic wait_n_o,
  output logic wait_oe_o
);

  localparam int SW = $bits(chc_pkg::chc_host_in_type);

  // Three-flop synchronisers for the host pins.
  logic [SW-1:0] s1_q, s2_q, s3_q;
  logic [SW-1:0] s1_d, s2_d, s3_d;
  chc_pkg::chc_host_in_type hs_d;
  logic [SW-1:0] stable_q, stable_d;

  always_comb begin
    s1_d = host_i;
    s2_d = s1_q;
    s3_d = s2_q;
    // A change is accepted only when the second and third flops agree.
    stable_d = stable_q;
    for (int i = 0; i < SW; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        stable_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q <= chc_pkg::SYNC_RST;
      s2_q <= chc_pkg::SYNC_RST;
      s3_q <= chc_pkg::SYNC_RST;
      stable_q <= chc_pkg::SYNC_RST;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      stable_q <= stable_d;
    end
  end

  // Only agreed samples reach the decode, so a pin caught mid-change is ignored.
  assign hs_d = chc_pkg::chc_host_in_type'(stable_q);

  // Mode and initialization state.
  chc_pkg::chc_state_type st_q, st_d;
  chc_pkg::chc_mode_type mode_q, mode_d;
  logic [chc_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic seen_idle_q, seen_idle_d;
  logic card_rst;

  // Reset polarity follows the latched mode.
  function automatic logic reset_active(input chc_pkg::chc_mode_type m,
                                        input logic pin);
    if (m == chc_pkg::MODE_IDE) begin
      return !pin;
    end
    return pin;
  endfunction : reset_active

  assign card_rst = reset_active(mode_q, hs_d.reset_pin);

  always_comb begin
    st_d = st_q;
    mode_d = mode_q;
    cnt_d = cnt_q;
    seen_idle_d = seen_idle_q;
    case (st_q)
      chc_pkg::ST_RSTHD: begin
        // The mode strap is sampled while reset is held.
        mode_d = hs_d.mode_sel_n ? chc_pkg::MODE_MEM : chc_pkg::MODE_IDE;
        if (!reset_active(mode_d, hs_d.reset_pin)) begin
          st_d = chc_pkg::ST_INIT;
          cnt_d = '0;
          seen_idle_d = 1'b1;
        end
      end
      chc_pkg::ST_INIT: begin
        if (card_rst) begin
          st_d = chc_pkg::ST_RSTHD;
        end else if (cnt_q == chc_pkg::CNT_W'(chc_pkg::INIT_CYCLES - 1)) begin
          st_d = chc_pkg::ST_RUN;
        end else begin
          cnt_d = cnt_q + chc_pkg::CNT_W'(1);
        end
      end
      chc_pkg::ST_RUN: begin
        if (card_rst) begin
          st_d = chc_pkg::ST_RSTHD;
        end else if (mode_q == chc_pkg::MODE_MEM && core_i.io_sel) begin
          // I/O mode has no strap of its own: the core reports it once the host
          // has written the configuration, and the shared pins follow two clocks later.
          mode_d = chc_pkg::MODE_IO;
        end else if (mode_q == chc_pkg::MODE_IO && !core_i.io_sel) begin
          mode_d = chc_pkg::MODE_MEM;
        end
      end
      default: st_d = chc_pkg::ST_RSTHD;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= chc_pkg::ST_RSTHD;
      mode_q <= chc_pkg::MODE_MEM;
      cnt_q <= '0;
      seen_idle_q <= 1'b0;
    end else begin
      st_q <= st_d;
      mode_q <= mode_d;
      cnt_q <= cnt_d;
      seen_idle_q <= seen_idle_d;
    end
  end

  // Interrupt pulse stretcher for I/O pulse mode.
  // A stretched strobe stays wide enough for a slow host socket to latch it.
  logic [1:0] pcnt_q, pcnt_d;
  logic irq_prev_q, irq_prev_d;

  always_comb begin
    irq_prev_d = core_i.irq;
    pcnt_d = pcnt_q;
    if (core_i.irq && !irq_prev_q) begin
      pcnt_d = 2'(chc_pkg::PULSE_CYCLES - 1);
    end else if (pcnt_q != chc_pkg::PULSE_RST) begin
      pcnt_d = pcnt_q - 2'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pcnt_q <= chc_pkg::PULSE_RST;
      irq_prev_q <= 1'b0;
    end else begin
      pcnt_q <= pcnt_d;
      irq_prev_q <= irq_prev_d;
    end
  end

  // Registered outputs.
  logic run;
  logic irq_pulse;
  logic rdy_d, rdy_oe_d, wp_d, csel_d, asel_d, mw_d, cw_d, dack_d;
  logic we_prev_q;
  logic run_q;

  assign run = (st_q == chc_pkg::ST_RUN);
  assign irq_pulse = core_i.irq && !irq_prev_q || (pcnt_q != chc_pkg::PULSE_RST);

  always_comb begin
    rdy_d = 1'b0;
    rdy_oe_d = 1'b1;
    wp_d = 1'b1;
    csel_d = 1'b0;
    asel_d = 1'b0;
    mw_d = 1'b0;
    cw_d = 1'b0;
    dack_d = 1'b0;
    case (mode_q)
      chc_pkg::MODE_MEM: begin
        // Ready low during init; reset held before its first release keeps ready high
        if (st_q == chc_pkg::ST_RSTHD) begin
          rdy_d = !seen_idle_q;
        end else begin
          rdy_d = run && !core_i.busy;
        end
        wp_d = !run;
        csel_d = run && hs_d.reg_sel_n;
        asel_d = run && !hs_d.reg_sel_n;
        mw_d = run && hs_d.we_n && !we_prev_q;
      end
      chc_pkg::MODE_IO: begin
        rdy_d = !(run && (core_i.irq_level_mode ? core_i.irq : irq_pulse));
        wp_d = !(run && core_i.port16);
        cw_d = run && hs_d.we_n && !we_prev_q;
      end
      chc_pkg::MODE_IDE: begin
        rdy_d = run && core_i.irq;
        wp_d = !(run && core_i.word_xfer);
        dack_d = run && core_i.dma_enabled && !hs_d.dmack_n;
      end
      default: begin
        rdy_d = 1'b0;
      end
    endcase
  end

  logic rdy_q, rdy_oe_q, wp_q, csel_q, asel_q, mw_q, cw_q, dack_q, crst_q;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdy_q <= 1'b0;
      rdy_oe_q <= 1'b1;
      wp_q <= 1'b1;
      csel_q <= 1'b0;
      asel_q <= 1'b0;
      mw_q <= 1'b0;
      cw_q <= 1'b0;
      dack_q <= 1'b0;
      crst_q <= 1'b1;
      we_prev_q <= 1'b1;
    end else begin
      rdy_q <= rdy_d;
      rdy_oe_q <= rdy_oe_d;
      wp_q <= wp_d;
      csel_q <= csel_d;
      asel_q <= asel_d;
      mw_q <= mw_d;
      cw_q <= cw_d;
      dack_q <= dack_d;
      crst_q <= (st_d == chc_pkg::ST_RSTHD);
      we_prev_q <= hs_d.we_n;
    end
  end

  assign rdy_irq_o = rdy_q;
  assign rdy_irq_oe_o = rdy_oe_q;
  assign wp_io16_o = wp_q;
  assign common_sel_o = csel_q;
  assign attr_sel_o = asel_q;
  assign mem_write_o = mw_q;
  assign cfg_write_o = cw_q;
  assign dma_ack_o = dack_q;
  assign card_reset_o = crst_q;
  assign init_done_o = run_q;
  assign mode_o = mode_q;
  assign wait_n_o = 1'b1;
  assign wait_oe_o = 1'b1;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run_q <= 1'b0;
    end else begin
      run_q <= (st_d == chc_pkg::ST_RUN);
    end
  end

endmodule : chc_top
